// file: fcs_pkg.sv
// Package: operations, formats, state image layout and conversion constants
package fcs_pkg;

  typedef enum logic [2:0] {
    op_load               = 3'h0,
    op_store              = 3'h1,
    load_environment_op   = 3'h2,
    restore_full_state_op = 3'h3,
    store_environment_op  = 3'h4,
    save_full_state_op    = 3'h5
  } fcs_op_type;

  typedef enum logic [2:0] {
    fmt_single = 3'h0,
    fmt_double = 3'h1,
    fmt_ext    = 3'h2,
    fmt_word   = 3'h3,
    fmt_short  = 3'h4,
    fmt_long   = 3'h5,
    fmt_bcd    = 3'h6
  } fcs_fmt_type;

  typedef enum logic [2:0] {
    st_idle   = 3'h1,
    st_xfer   = 3'h2,
    st_finish = 3'h4
  } fcs_state_type;

  // Exponent biases: 127, 1023, 16383
  localparam logic [15:0] BIAS_SINGLE   = 16'h007F;
  localparam logic [15:0] BIAS_DOUBLE   = 16'h03FF;
  localparam logic [15:0] BIAS_EXT      = 16'h3FFF;
  localparam logic [10:0] EXP_ONES_SGL  = 11'h0FF;
  localparam logic [10:0] EXP_ONES_DBL  = 11'h7FF;
  localparam logic [14:0] EXP_ONES_EXT  = 15'h7FFF;
  // Significand bits kept, integer bit included
  localparam logic [6:0]  KEEP_SINGLE   = 7'h18;
  localparam logic [6:0]  KEEP_DOUBLE   = 7'h35;
  localparam logic [15:0] INT_EXP       = 16'h403E;

  // Operand lengths in bytes
  localparam logic [6:0]  LEN_SINGLE    = 7'h04;
  localparam logic [6:0]  LEN_DOUBLE    = 7'h08;
  localparam logic [6:0]  LEN_EXT       = 7'h0A;
  localparam logic [6:0]  LEN_WORD      = 7'h02;
  localparam logic [6:0]  LEN_SHORT     = 7'h04;
  localparam logic [6:0]  LEN_LONG      = 7'h08;
  localparam logic [6:0]  LEN_BCD       = 7'h0A;
  localparam logic [6:0]  ENV_BYTES     = 7'h1C;
  localparam logic [6:0]  SAVE_BYTES    = 7'h6C;

  // Byte offsets inside the 32-bit environment image
  localparam int OFS_CTRL   = 'h00;
  localparam int OFS_STAT   = 'h04;
  localparam int OFS_TAG    = 'h08;
  localparam int OFS_IP_OFF = 'h0C;
  localparam int OFS_IP_SEL = 'h10;
  localparam int OFS_OPCODE = 'h12;
  localparam int OFS_DP_OFF = 'h14;
  localparam int OFS_DP_SEL = 'h18;

  // Reset, reinit and field positions
  localparam logic [15:0] CTRL_INIT     = 16'h037F;
  localparam logic [15:0] TAG_ALL_EMPTY = 16'hFFFF;
  localparam logic [1:0]  TAG_VALID     = 2'h0;
  localparam logic [1:0]  TAG_ZERO      = 2'h1;
  localparam logic [1:0]  TAG_SPECIAL   = 2'h2;
  localparam logic [1:0]  TAG_EMPTY     = 2'h3;
  localparam int          CTRL_IM_BIT   = 'h0;
  localparam int          RC_LSB        = 'hA;
  localparam int          STAT_IE_BIT   = 'h0;
  localparam int          STAT_PE_BIT   = 'h5;
  localparam logic [1:0]  RC_NEAREST    = 2'h0;
  localparam logic [1:0]  RC_DOWN       = 2'h1;
  localparam logic [1:0]  RC_UP         = 2'h2;

  // Real indefinite quiet NaN per format
  localparam logic [31:0] INDEF_SINGLE  = 32'hFFC00000;
  localparam logic [63:0] INDEF_DOUBLE  = 64'hFFF8000000000000;
  localparam logic [79:0] INDEF_EXT     = 80'hFFFFC000000000000000;

  function automatic logic [6:0] fcs_len(input fcs_fmt_type f);
    case (f)
      fmt_single: fcs_len = LEN_SINGLE;
      fmt_double: fcs_len = LEN_DOUBLE;
      fmt_word:   fcs_len = LEN_WORD;
      fmt_short:  fcs_len = LEN_SHORT;
      fmt_long:   fcs_len = LEN_LONG;
      fmt_bcd:    fcs_len = LEN_BCD;
      default:    fcs_len = LEN_EXT;
    endcase
  endfunction : fcs_len

endpackage : fcs_pkg

// file: fcs_norm.sv
// Normaliser: shifts a magnitude until its top bit is set, adjusting the exponent
`timescale 1ns/1ps
module fcs_norm
  import fcs_pkg::*;
#(
  parameter int MANT_W = 64,
  parameter int EXP_W  = 15
) (
  input  wire logic              sign,
  input  wire logic [MANT_W-1:0] mant,
  input  wire logic [EXP_W:0]    exp_in,
  output logic [MANT_W+EXP_W:0]  ext
);
  localparam int LZ_W = $clog2(MANT_W) + 1;

  logic [LZ_W-1:0]   lz;
  logic [EXP_W:0]    exp_adj;
  logic [MANT_W-1:0] shifted;

  // Leading zeros; the highest set bit wins since it is visited last
  always_comb begin
    lz = '0;
    for (int i = 0; i < MANT_W; i++) begin
      if (mant[i]) lz = LZ_W'(MANT_W - 1 - i);
    end
    shifted = mant << lz;
    exp_adj = exp_in - (EXP_W + 1)'(lz);
    // Zero keeps integer bit and exponent clear
    if (mant == '0) ext = {sign, {(MANT_W + EXP_W){1'b0}}};
    else ext = {sign, exp_adj[EXP_W-1:0], shifted};
  end
endmodule : fcs_norm

// file: fcs_convert_unit.sv
// Format conversion, operand transfer and state load/save for the float unit
`timescale 1ns/1ps
// Contract
// - Environment load fills control, status, tag, pointers, opcode; data registers untouched.
// - Full restore loads environment and all eight data registers.
// - Non-extended memory operands become extended real before any arithmetic.
// - Memory operands are little-endian, lowest byte at starting address.
// - Transfers use only the starting address; length follows from type.
// - Single/double store fraction only; implied integer is one except zero/denormal.
// - Extended real holds integer bit at 63, top fraction bit at 62.
// - Extended integer bit one for normal/infinity/NaN, zero for zero/denormal.
// - Biased exponents: 127 single, 1023 double, 16383 extended.
// - Real operands span 4, 8 or 10 consecutive bytes.
// - Denormals accepted in all real formats, never flushed.
// - Real formats follow IEEE single, double, double-extended layouts.
// - Masked invalid operation writes the real indefinite quiet NaN.
// - Loaded tag image honours only empty; other tags derived from contents.
// - Saved pointers: offset in bits 0-31, selector in bits 32-47.
// - Environment store saves environment; full save adds data then reinitialises.
module fcs_convert_unit
  import fcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        op_start,
  input  wire fcs_op_type  op_code,
  input  wire fcs_fmt_type op_fmt,
  input  wire logic [31:0] op_addr,
  input  wire logic [2:0]  op_reg,
  output logic             op_busy,
  output logic             op_done,
  output logic             op_invalid,
  input  wire logic        ptr_update,
  input  wire logic [47:0] ptr_ip,
  input  wire logic [47:0] ptr_dp,
  input  wire logic [10:0] ptr_opcode,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic [15:0]      ctrl_word,
  output logic [15:0]      status_word,
  output logic [15:0]      tag_word,
  output logic [79:0]      load_result
);
  localparam int ENV_W = 8 * int'(ENV_BYTES);
  localparam int IMG_W = 8 * int'(SAVE_BYTES);

  fcs_state_type    state;
  fcs_op_type       cur_op;
  fcs_fmt_type      cur_fmt;
  logic [2:0]       cur_reg;
  logic [6:0]       cnt, len, next_len;
  logic [IMG_W-1:0] img;
  logic [7:0][79:0] dreg;
  logic [15:0]      ctrl, stat, tag, next_tag;
  logic [47:0]      ip, dp;
  logic [10:0]      opc;
  logic [ENV_W-1:0] env_img;
  logic             start, skip, env_in, last;

  assign start       = ce && op_start && (state == st_idle);
  assign env_in      = (cur_op == load_environment_op) || (cur_op == restore_full_state_op);
  assign last        = mem_ack && (cnt == len - 7'h1);
  assign op_busy     = (state != st_idle);
  assign mem_req     = (state == st_xfer);
  assign mem_wdata   = img[7:0];
  assign ctrl_word   = ctrl;
  assign status_word = stat;
  assign tag_word    = tag;

  // Environment image, lowest byte first; reserved bits read as zero
  assign env_img = {16'h0, dp[47:32], dp[31:0], 5'h0, opc, ip[47:32], ip[31:0],
                    16'h0, tag, 16'h0, stat, 16'h0, ctrl};

  function automatic logic [1:0] fcs_class(input logic [79:0] v);
    if (v[78:64] == 15'h0 && v[63:0] == 64'h0) fcs_class = TAG_ZERO;
    else if (v[78:64] == EXP_ONES_EXT || v[78:64] == 15'h0 || !v[63]) fcs_class = TAG_SPECIAL;
    else fcs_class = TAG_VALID;
  endfunction : fcs_class

  // ---------------- Store conversion: extended to narrower real ----------------
  logic [79:0]        src, st_img;
  logic               src_empty, st_inexact, g, sticky, inc, ovf, ovf_inf;
  logic [1:0]         rc;
  logic [6:0]         keep;
  logic signed [17:0] be, shv;
  logic [127:0]       wide;
  logic [64:0]        kr;
  logic [63:0]        frac;
  logic [10:0]        ef, ef_ones;

  // Rounding uses a 128-bit window so guard and sticky fall out of one shift
  always_comb begin
    src       = dreg[op_reg];
    src_empty = (tag[2*op_reg+:2] == TAG_EMPTY);
    rc        = ctrl[RC_LSB+:2];
    keep      = (op_fmt == fmt_single) ? KEEP_SINGLE : KEEP_DOUBLE;
    ef_ones   = (op_fmt == fmt_single) ? EXP_ONES_SGL : EXP_ONES_DBL;
    be = $signed({3'h0, (src[78:64] == 15'h0) ? 15'h1 : src[78:64]})
       - $signed({2'h0, BIAS_EXT})
       + $signed({2'h0, (op_fmt == fmt_single) ? BIAS_SINGLE : BIAS_DOUBLE});
    shv = 18'sh40 - $signed({11'h0, keep}) + ((be < 18'sh1) ? (18'sh1 - be) : 18'sh0);
    wide   = {src[63:0], 64'h0} >> ((shv > 18'sh7F) ? 7'h7F : shv[6:0]);
    g      = wide[63];
    sticky = |wide[62:0];
    case (rc)
      RC_NEAREST: inc = g & (sticky | wide[64]);
      RC_DOWN:    inc = src[79] & (g | sticky);
      RC_UP:      inc = ~src[79] & (g | sticky);
      default:    inc = 1'b0;
    endcase
    kr = {1'b0, wide[127:64]} + {64'h0, inc};
    if ((kr >> keep) != 65'h0) begin
      kr = kr >> 1;
      be = be + 18'sh1;
    end
    // Tiny results stay denormal instead of flushing
    if (be < 18'sh1) be = ((kr >> (keep - 7'h1)) != 65'h0) ? 18'sh1 : 18'sh0;
    frac       = kr[63:0] & ((64'h1 << (keep - 7'h1)) - 64'h1);
    ovf        = (be >= $signed({7'h0, ef_ones}));
    ovf_inf    = (rc == RC_NEAREST) || (rc == RC_UP && !src[79]) || (rc == RC_DOWN && src[79]);
    st_inexact = (g | sticky) && (op_fmt != fmt_ext);
    ef         = be[10:0];
    if (src[78:64] == EXP_ONES_EXT) begin
      ef         = ef_ones;
      frac       = {1'h0, src[62:0]} >> (7'h40 - keep);
      st_inexact = 1'b0;
    end else if (src[63:0] == 64'h0) begin
      ef         = 11'h0;
      frac       = 64'h0;
      st_inexact = 1'b0;
    end else if (ovf) begin
      ef   = ovf_inf ? ef_ones : ef_ones - 11'h1;
      frac = ovf_inf ? 64'h0 : ((64'h1 << (keep - 7'h1)) - 64'h1);
    end
    case (op_fmt)
      fmt_single: st_img = src_empty ? {48'h0, INDEF_SINGLE} : {48'h0, src[79], ef[7:0], frac[22:0]};
      fmt_double: st_img = src_empty ? {16'h0, INDEF_DOUBLE} : {16'h0, src[79], ef, frac[51:0]};
      default:    st_img = src_empty ? INDEF_EXT : src;
    endcase
  end

  // ---------------- Load conversion: memory image to extended real ----------------
  logic [79:0] raw, ld_ext, norm_ext, spec_val;
  logic [63:0] iv, bv;
  logic        nsign, special;
  logic [63:0] nmant;
  logic [15:0] nexp;

  always_comb begin
    raw      = img[79:0];
    nsign    = 1'b0;
    nmant    = 64'h0;
    nexp     = INT_EXP;
    special  = 1'b0;
    spec_val = 80'h0;
    iv       = 64'h0;
    bv       = 64'h0;
    case (cur_fmt)
      fmt_single: begin
        nsign    = raw[31];
        nmant    = {|raw[30:23], raw[22:0], 40'h0};
        nexp     = ((raw[30:23] == 8'h0) ? 16'h1 : {8'h0, raw[30:23]}) - BIAS_SINGLE + BIAS_EXT;
        special  = &raw[30:23];
        spec_val = {raw[31], EXP_ONES_EXT, 1'b1, raw[22:0], 40'h0};
      end
      fmt_double: begin
        nsign    = raw[63];
        nmant    = {|raw[62:52], raw[51:0], 11'h0};
        nexp     = ((raw[62:52] == 11'h0) ? 16'h1 : {5'h0, raw[62:52]}) - BIAS_DOUBLE + BIAS_EXT;
        special  = &raw[62:52];
        spec_val = {raw[63], EXP_ONES_EXT, 1'b1, raw[51:0], 11'h0};
      end
      fmt_word, fmt_short, fmt_long: begin
        if (cur_fmt == fmt_word) iv = {{48{raw[15]}}, raw[15:0]};
        else if (cur_fmt == fmt_short) iv = {{32{raw[31]}}, raw[31:0]};
        else iv = raw[63:0];
        nsign = iv[63];
        nmant = iv[63] ? (64'h0 - iv) : iv;
      end
      fmt_bcd: begin
        // Eighteen digits, most significant first; sign in the top byte
        for (int i = 17; i >= 0; i--) bv = (bv * 64'hA) + {60'h0, raw[4*i+:4]};
        nsign = raw[79];
        nmant = bv;
      end
      default: ;
    endcase
    if (cur_fmt == fmt_ext) ld_ext = raw;
    else if (special) ld_ext = spec_val;
    else ld_ext = norm_ext;
  end

  fcs_norm #(.MANT_W(64), .EXP_W(15)) u_norm (
    .sign   (nsign),
    .mant   (nmant),
    .exp_in (nexp),
    .ext    (norm_ext)
  );

  // Loaded tag image: only empty is trusted, otherwise look at the register
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (img[8*OFS_TAG+2*i+:2] == TAG_EMPTY) next_tag[2*i+:2] = TAG_EMPTY;
      else if (cur_op == restore_full_state_op) next_tag[2*i+:2] = fcs_class(img[ENV_W+80*i+:80]);
      else next_tag[2*i+:2] = fcs_class(dreg[i]);
    end
  end

  // Transfer length from operation and format
  always_comb begin
    case (op_code)
      op_load, op_store:                         next_len = fcs_len(op_fmt);
      load_environment_op, store_environment_op: next_len = ENV_BYTES;
      default:                                   next_len = SAVE_BYTES;
    endcase
  end
  // Unmasked invalid store writes nothing to memory
  assign skip = (op_code == op_store) && src_empty && !ctrl[CTRL_IM_BIT];

  // Sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= st_idle;
      cur_op  <= op_load;
      cur_fmt <= fmt_single;
      cur_reg <= 3'h0;
      cnt     <= 7'h0;
      len     <= 7'h0;
      mem_we  <= 1'b0;
    end else if (ce) begin
      case (state)
        st_idle: if (op_start) begin
          cur_op  <= op_code;
          cur_fmt <= op_fmt;
          cur_reg <= op_reg;
          cnt     <= 7'h0;
          len     <= next_len;
          mem_we  <= (op_code == op_store) || (op_code == store_environment_op)
                     || (op_code == save_full_state_op);
          state   <= skip ? st_finish : st_xfer;
        end
        st_xfer: if (mem_ack) begin
          cnt <= cnt + 7'h1;
          if (last) state <= st_finish;
        end
        st_finish: state <= st_idle;
        default:   state <= st_idle;
      endcase
    end
  end

  // Address: only the start is given, each byte goes one higher
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mem_addr <= 32'h0;
    else if (ce && start) mem_addr <= op_addr;
    else if (ce && mem_req && mem_ack) mem_addr <= mem_addr + 32'h1;
  end

  // Byte image: stores shift out low byte first, loads fill by byte index
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) img <= '0;
    else if (ce && start) begin
      if (op_code == op_store) img <= {{(IMG_W-80){1'b0}}, st_img};
      else img <= {dreg, env_img};
    end else if (ce && mem_req && mem_ack) begin
      if (mem_we) img <= img >> 8;
      else img[8*cnt+:8] <= mem_rdata;
    end
  end

  // Completion and invalid pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_done    <= 1'b0;
      op_invalid <= 1'b0;
    end else if (ce) begin
      op_done    <= (state == st_finish);
      op_invalid <= start && (op_code == op_store) && src_empty;
    end
  end

  // Control, status and tag words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_INIT;
      stat <= 16'h0;
      tag  <= TAG_ALL_EMPTY;
    end else if (ce) begin
      if (start && op_code == op_store) begin
        if (src_empty) stat[STAT_IE_BIT] <= 1'b1;
        else if (st_inexact) stat[STAT_PE_BIT] <= 1'b1;
      end
      if (state == st_finish) begin
        if (env_in) begin
          ctrl <= img[8*OFS_CTRL+:16];
          stat <= img[8*OFS_STAT+:16];
          tag  <= next_tag;
        end else if (cur_op == save_full_state_op) begin
          ctrl <= CTRL_INIT;
          stat <= 16'h0;
          tag  <= TAG_ALL_EMPTY;
        end else if (cur_op == op_load) begin
          tag[2*cur_reg+:2] <= fcs_class(ld_ext);
        end
      end
    end
  end

  // Pointers and opcode; untouched by the state operations except load/init
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ip  <= 48'h0;
      dp  <= 48'h0;
      opc <= 11'h0;
    end else if (ce) begin
      if (state == st_finish && env_in) begin
        ip  <= {img[8*OFS_IP_SEL+:16], img[8*OFS_IP_OFF+:32]};
        dp  <= {img[8*OFS_DP_SEL+:16], img[8*OFS_DP_OFF+:32]};
        opc <= img[8*OFS_OPCODE+:11];
      end else if (state == st_finish && cur_op == save_full_state_op) begin
        ip  <= 48'h0;
        dp  <= 48'h0;
        opc <= 11'h0;
      end else if (state == st_idle && ptr_update && !op_start) begin
        ip  <= ptr_ip;
        dp  <= ptr_dp;
        opc <= ptr_opcode;
      end
    end
  end

  // Data registers: written by a value load or a full restore only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dreg        <= '0;
      load_result <= 80'h0;
    end else if (ce && state == st_finish) begin
      if (cur_op == restore_full_state_op) dreg <= img[IMG_W-1:ENV_W];
      else if (cur_op == op_load) begin
        dreg[cur_reg] <= ld_ext;
        load_result   <= ld_ext;
      end
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_finish(fcs_op_type o);
    state == st_finish && ce && cur_op == o;
  endsequence
  sequence s_store_empty_dbl;
    start && op_code == op_store && op_fmt == fmt_double && src_empty && ctrl[CTRL_IM_BIT];
  endsequence

  a_env_data_kept: assert property (s_finish(load_environment_op) |=> $stable(dreg))
    else $error("environment load changed data registers");
  a_restore_data: assert property (s_finish(restore_full_state_op) |=>
    dreg == $past(img[IMG_W-1:ENV_W])) else $error("restore did not load data registers");
  a_single_bias: assert property (s_finish(op_load) ##0 (cur_fmt == fmt_single &&
    img[30:23] != 8'h0 && img[30:23] != 8'hFF) |=> load_result[63] &&
    load_result[78:64] == 15'($past(img[30:23]) + BIAS_EXT - BIAS_SINGLE))
    else $error("single load exponent or integer bit wrong");
  a_denorm_kept: assert property (s_finish(op_load) ##0 (cur_fmt == fmt_single &&
    img[30:23] == 8'h0 && img[22:0] != 23'h0) |=> load_result[63] &&
    load_result[78:64] < 15'h3F81) else $error("single denormal not normalised");
  a_start_addr: assert property (start && !skip |=> mem_addr == $past(op_addr))
    else $error("transfer did not begin at start address");
  a_addr_step: assert property (mem_req && mem_ack && ce |=>
    mem_addr == $past(mem_addr) + 32'h1) else $error("address did not advance by one");
  a_real_len: assert property (mem_req && ce && last && cur_op == op_store |->
    cnt == ((cur_fmt == fmt_single) ? LEN_SINGLE : (cur_fmt == fmt_double) ? LEN_DOUBLE
      : LEN_EXT) - 7'h1) else $error("store length wrong");
  a_indefinite: assert property (s_store_empty_dbl |=> img[63:0] == INDEF_DOUBLE)
    else $error("masked invalid store not indefinite");
  a_tag_empty: assert property (state == st_finish && ce && env_in &&
    img[8*OFS_TAG+14+:2] == TAG_EMPTY |=> tag[15:14] == TAG_EMPTY)
    else $error("tag empty lost");
  a_save_init: assert property (s_finish(save_full_state_op) |=> ctrl == CTRL_INIT &&
    tag == TAG_ALL_EMPTY && ip == 48'h0) else $error("full save did not reinitialise");

endmodule : fcs_convert_unit

// file: fcs_mem_model.sv
// Byte-wide memory partner for the convert unit, prompt or stalling
`timescale 1ns/1ps
module fcs_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:511];
  logic       ph = 1'b0;
  int         acks = 0;
  // Slow mode answers every other cycle only
  assign mem_ack = mem_req & (~slow | ph);
  // Inverted data off the ack, so early sampling shows up
  assign mem_rdata = mem_ack ? mem[mem_addr[8:0]] : ~mem[mem_addr[8:0]];
  // Byte accept and write
  always @(posedge clk) begin
    ph <= ~ph;
    if (mem_ack) begin
      acks <= acks + 1;
      if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
    end
  end
endmodule : fcs_mem_model

// file: tb_fcs_convert_unit.sv
// Self-checking bench for the format convert and state load unit
`timescale 1ns/1ps
module tb_fcs_convert_unit import fcs_pkg::*; ;
  logic        clk = 0, rstn = 0, op_start = 0, ptr_update = 0, slow = 0, ce = 1;
  fcs_op_type  op_code = op_load;
  fcs_fmt_type op_fmt = fmt_single;
  logic [31:0] op_addr = 0, mem_addr;
  logic [2:0]  op_reg = 0;
  logic [47:0] ptr_ip = 0, ptr_dp = 0;
  logic [10:0] ptr_opcode = 0;
  logic        op_busy, op_done, op_invalid, mem_req, mem_we, mem_ack;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [15:0] ctrl_word, status_word, tag_word;
  logic [79:0] load_result;
  int          error_cnt = 0, tests_run = 0, inv_cnt = 0;

  always #10 clk = ~clk;
  // Pulse counter, since the flag stands one cycle only
  always @(posedge clk) if (op_invalid === 1'b1) inv_cnt++;

  fcs_convert_unit u_dut (.clk(clk), .rstn(rstn), .ce(ce), .op_start(op_start),
    .op_code(op_code), .op_fmt(op_fmt), .op_addr(op_addr), .op_reg(op_reg),
    .op_busy(op_busy), .op_done(op_done), .op_invalid(op_invalid),
    .ptr_update(ptr_update), .ptr_ip(ptr_ip), .ptr_dp(ptr_dp), .ptr_opcode(ptr_opcode),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .ctrl_word(ctrl_word),
    .status_word(status_word), .tag_word(tag_word), .load_result(load_result));
  fcs_mem_model u_mem (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  task chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Little-endian image helpers
  task put(input int a, input int n, input logic [79:0] v);
    for (int i = 0; i < n; i++) u_mem.mem[a+i] = v[8*i+:8];
  endtask : put
  function automatic logic [79:0] get(input int a, input int n);
    get = '0;
    for (int i = 0; i < n; i++) get[8*i+:8] = u_mem.mem[a+i];
  endfunction : get
  // One request, then a bounded wait for the done pulse
  task run(input fcs_op_type c, input fcs_fmt_type f, input int a, input logic [2:0] r);
    @(negedge clk);
    op_code = c; op_fmt = f; op_addr = a; op_reg = r; op_start = 1;
    u_mem.acks = 0; inv_cnt = 0;
    @(negedge clk);
    op_start = 0;
    for (int k = 0; k < 400 && op_done !== 1'b1; k++) @(negedge clk);
    chk("op_done", 80'h1, op_done);
  endtask : run
  task ld(input fcs_fmt_type f, input int n, input logic [79:0] v, input logic [2:0] r,
          input logic [79:0] e);
    put('h10, n, v);
    run(op_load, f, 'h10, r);
    chk("load_result", e, load_result);
    chk("load bytes", n, u_mem.acks);
  endtask : ld
  task st(input fcs_fmt_type f, input logic [2:0] r, input int n, input logic [79:0] e);
    run(op_store, f, 'h40, r);
    chk("stored", e, get('h40, n));
    chk("store bytes", n, u_mem.acks);
  endtask : st

  task t_reset;
    chk("ctrl", 16'h037F, ctrl_word);
    chk("status", 16'h0000, status_word);
    chk("tag", 16'hFFFF, tag_word);
  endtask : t_reset
  // Clock enable low must hold off a pending request
  task t_freeze;
    @(negedge clk);
    ce = 0;
    op_start = 1;
    repeat (3) @(negedge clk);
    chk("frozen busy", 0, op_busy);
    op_start = 0;
    ce = 1;
  endtask : t_freeze
  task t_loads;
    ld(fmt_single, 4, 32'h00000001, 0, 80'h3F6A8000000000000000);
    slow = 1;
    ld(fmt_double, 8, 64'h3FF0000000000000, 1, 80'h3FFF8000000000000000);
    slow = 0;
    ld(fmt_word, 2, 16'h0005, 2, 80'h4001A000000000000000);
    ld(fmt_single, 4, 32'h0, 3, 80'h0);
    ld(fmt_ext, 10, 80'hC000C90FDAA22168C235, 4, 80'hC000C90FDAA22168C235);
    ld(fmt_double, 8, 64'h3FF0000010000001, 6, 80'h3FFF8000008000000800);
    ld(fmt_single, 4, 32'hC0490FDB, 7, 80'hC000C90FDB0000000000);
    ld(fmt_bcd, 10, 80'h80000000000000000123, 4, 80'hC005F600000000000000);
    ld(fmt_short, 4, 32'hFFFFFFFF, 3, 80'hBFFF8000000000000000);
    ld(fmt_long, 8, 64'h0000000000000100, 3, 80'h40078000000000000000);
  endtask : t_loads
  task t_stores;
    st(fmt_single, 1, 4, 32'h3F800000);
    st(fmt_double, 2, 8, 64'h4014000000000000);
    st(fmt_single, 6, 4, 32'h3F800001);
    chk("inexact flag", 1'b1, status_word[STAT_PE_BIT]);
    st(fmt_single, 5, 4, INDEF_SINGLE);
    chk("invalid flag", 1'b1, status_word[STAT_IE_BIT]);
    st(fmt_double, 5, 8, INDEF_DOUBLE);
  endtask : t_stores
  // Round up, invalid unmasked; tag image claims reg0 special
  task t_env_load;
    put('h80, 8, 64'h0000000000000B7E);
    put('h88, 10, 80'h0000FFFE);
    put('h92, 10, 80'h0);
    run(load_environment_op, fmt_ext, 'h80, 0);
    chk("env bytes", 28, u_mem.acks);
    chk("ctrl", 16'h0B7E, ctrl_word);
    chk("tag", 16'hFFFC, tag_word);
    run(op_store, fmt_single, 'h50, 7);
    chk("invalid pulse", 1, inv_cnt);
    chk("refused bytes", 0, u_mem.acks);
    st(fmt_single, 0, 4, 32'h00000001);
  endtask : t_env_load
  task t_env_store;
    @(negedge clk);
    ptr_ip = 48'h012389ABCDEF; ptr_dp = 48'h045676543210; ptr_opcode = 11'h5A3;
    ptr_update = 1;
    @(negedge clk);
    ptr_update = 0;
    run(store_environment_op, fmt_ext, 'hC0, 0);
    chk("env bytes", 28, u_mem.acks);
    chk("env ctrl", 32'h00000B7E, get('hC0, 4));
    chk("env tag", 32'h0000FFFC, get('hC8, 4));
    chk("env ip", 64'h05A3012389ABCDEF, get('hCC, 8));
    chk("env dp", 64'h0000045676543210, get('hD4, 8));
  endtask : t_env_store
  task t_full;
    run(save_full_state_op, fmt_ext, 'h100, 0);
    chk("save bytes", 108, u_mem.acks);
    chk("saved reg1", 80'h3FFF8000000000000000, get('h126, 10));
    chk("reinit ctrl", 16'h037F, ctrl_word);
    chk("reinit tag", 16'hFFFF, tag_word);
    put('h11C, 10, 80'h3FFF8000000000000000);
    run(restore_full_state_op, fmt_ext, 'h100, 0);
    chk("restore bytes", 108, u_mem.acks);
    chk("ctrl", 16'h0B7E, ctrl_word);
    chk("tag", 16'hFFFC, tag_word);
    st(fmt_single, 0, 4, 32'h3F800000);
  endtask : t_full

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    t_reset();
    t_freeze();
    t_loads();
    t_stores();
    t_env_load();
    t_env_store();
    t_full();
    conclude();
  end
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule : tb_fcs_convert_unit
